/* uft_pkg.sv */
// shared constants for the serial frame transmitter
package uft_pkg;
    localparam int          DIV_W          = 8;
    localparam int          DIV_LOW_SPEED  = 64;
    localparam int          DIV_HIGH_SPEED = 16;
    localparam int          PRE_W          = 6;
    localparam int          FRAME_W        = 13;
    localparam int          CNT_W          = 4;
    localparam logic [CNT_W-1:0] BITS_EIGHT = 4'h8;
    localparam logic [CNT_W-1:0] BITS_NINE  = 4'h9;
    localparam logic [7:0]  RST_DIVISOR    = 8'h00;
    localparam logic        RST_NINE       = 1'b0;
    localparam logic        RST_PAR_EN     = 1'b0;
    localparam logic        RST_PAR_ODD    = 1'b0;
    localparam logic        RST_TWO_STOP   = 1'b0;
    localparam logic        RST_HIGH_SPEED = 1'b0;
endpackage : uft_pkg

/* uft_baud_gen.sv */
// baud tick generator: divides mclk by 64*(n+1) or 16*(n+1)
`timescale 1ns/10ps
`default_nettype none
module uft_baud_gen #(
    parameter int DIV_W = uft_pkg::DIV_W
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic             high_speed,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [uft_pkg::PRE_W-1:0] pre;
    logic [DIV_W-1:0]          cnt;
    logic                      pre_end;

    always_comb begin
        if (high_speed) begin
            pre_end = (pre == 6'(uft_pkg::DIV_HIGH_SPEED - 1));
        end else begin
            pre_end = (pre == 6'(uft_pkg::DIV_LOW_SPEED - 1));
        end
    end

    // prescaler then 8-bit divisor counter
    always_ff @(posedge mclk) begin
        if (rst || !run) begin
            pre  <= '0;
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_end) begin
                pre <= '0;
                if (cnt >= divisor) begin
                    cnt  <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt <= cnt + DIV_W'(1);
                end
            end else begin
                pre <= pre + 6'h01;
            end
        end
    end
endmodule : uft_baud_gen
`default_nettype wire

/* uft_transmitter.sv */
// serial frame transmitter with enable logic and status flags
// Notes on behaviour
// - nrz frame: start, 8 or 9 data, stops
// - parity even/odd/none; reset format is 8N1
// - data bits leave lsb first
// - one format and baud shared by both directions
// - each pin owned only when mode, global and its own enable set
// - idle line rests high
// - global disable frees pins, empties buffer
// - disable clears enables/flags, sets idle flags
// - disable aborts at once; config is kept
// - word length, parity type, parity, stop count
// - address mode: msb marks address character
// - stop count only affects transmitter
// - ninth bit comes from tx_bit_eight
// - shifter reloads only after stop bits sent
// - start needs enable, data and baud tick
// - tx enable clear aborts and resets transmitter
// - data writes ignored while empty flag low
// - empty flag cleared by status access then write
// - empty flag set when holding register free
// - idle write loads shifter, empty flag resets
// - tx idle flag set after frame completes
// - bit timing from 8-bit baud generator
// - rate = fh/(64 or 16 times n+1)
// - empty flag with irq enable raises shared flag
`timescale 1ns/10ps
`default_nettype none
module uft_transmitter #(
    parameter int DIV_W = uft_pkg::DIV_W
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             serial_mode_select,
    input  wire logic             port_global_enable,
    input  wire logic             tx_enable_set,
    input  wire logic             tx_enable_clr,
    input  wire logic             rx_enable_set,
    input  wire logic             rx_enable_clr,
    input  wire logic             break_request_set,
    input  wire logic             word_len_nine,
    input  wire logic             parity_type_sel,
    input  wire logic             parity_enable,
    input  wire logic             stop_count_sel,
    input  wire logic             tx_bit_eight,
    input  wire logic             baud_high_speed,
    input  wire logic [DIV_W-1:0] baud_divisor,
    input  wire logic             tx_empty_irq_en,
    input  wire logic             status_access,
    input  wire logic             data_write,
    input  wire logic [7:0]       data_in,
    input  wire logic             shared_irq_clr,
    output logic                  tx_out,
    output logic                  tx_oe_n,
    output logic                  rx_take,
    output logic                  tx_enable,
    output logic                  rx_enable,
    output logic                  break_request,
    output logic                  tx_empty_flag,
    output logic                  tx_idle_flag,
    output logic                  rx_idle_flag,
    output logic                  rx_available_flag,
    output logic                  shared_irq_flag,
    output logic                  cfg_nine,
    output logic                  cfg_par_en,
    output logic                  cfg_par_odd,
    output logic                  cfg_two_stop
);
    typedef enum logic [1:0] {
        UFT_IDLE  = 2'b00,
        UFT_START = 2'b01,
        UFT_DATA  = 2'b10,
        UFT_STOP  = 2'b11
    } uft_state_t;

    uft_state_t             state;
    logic [8:0]             hold;
    logic                   hold_full;
    logic [8:0]             tx_shift_reg;
    logic [uft_pkg::CNT_W-1:0] bit_cnt;
    logic                   stop_cnt;
    logic                   par_acc;
    logic                   armed;
    logic                   tick;
    logic                   port_on;
    logic                   tx_run;
    logic                   wr_ok;
    logic [uft_pkg::CNT_W-1:0] word_bits;
    logic [8:0]             word_in;
    logic                   load_now;

    // pins and transmitter only live with mode, global and their own enable set
    assign port_on = serial_mode_select && port_global_enable;
    assign tx_run  = port_on && tx_enable;
    // accepted write: status access armed and flag high
    assign wr_ok   = data_write && armed && tx_empty_flag && tx_run;
    assign word_bits = word_len_nine ? uft_pkg::BITS_NINE
                                     : uft_pkg::BITS_EIGHT;
    // ninth bit taken from tx_bit_eight, not the data byte
    assign word_in = {tx_bit_eight, data_in};
    // shifter takes new word only between frames
    assign load_now = (state == UFT_IDLE) && tick && hold_full;

    uft_baud_gen #(
        .DIV_W (DIV_W)
    ) u_baud (
        .mclk       (mclk),
        .rst        (rst),
        .run        (tx_run),
        .high_speed (baud_high_speed),
        .divisor    (baud_divisor),
        .tick       (tick)
    );

    // format re-registered from the inputs every cycle; shared by both directions
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_nine     <= uft_pkg::RST_NINE;
            cfg_par_en   <= uft_pkg::RST_PAR_EN;
            cfg_par_odd  <= uft_pkg::RST_PAR_ODD;
            cfg_two_stop <= uft_pkg::RST_TWO_STOP;
        end else begin
            cfg_nine     <= word_len_nine;
            cfg_par_en   <= parity_enable;
            cfg_par_odd  <= parity_type_sel;
            cfg_two_stop <= stop_count_sel;
        end
    end

    // enables; global disable clears them, config untouched
    always_ff @(posedge mclk) begin
        if (rst || !port_global_enable) begin
            tx_enable     <= 1'b0;
            rx_enable     <= 1'b0;
            break_request <= 1'b0;
        end else begin
            if (tx_enable_set) begin
                tx_enable <= 1'b1;
            end else if (tx_enable_clr) begin
                tx_enable <= 1'b0;
            end
            if (rx_enable_set) begin
                rx_enable <= 1'b1;
            end else if (rx_enable_clr) begin
                rx_enable <= 1'b0;
            end
            if (break_request_set) begin
                break_request <= 1'b1;
            end
        end
    end

    // receiver flags: only their disable values live here
    always_ff @(posedge mclk) begin
        if (rst || !port_global_enable) begin
            rx_available_flag <= 1'b0;
            rx_idle_flag      <= 1'b1;
        end else begin
            rx_available_flag <= rx_available_flag;
            rx_idle_flag      <= rx_idle_flag;
        end
    end

    // status access arms the next data write
    always_ff @(posedge mclk) begin
        if (rst || !port_global_enable) begin
            armed <= 1'b0;
        end else if (status_access) begin
            armed <= 1'b1;
        end else if (data_write) begin
            armed <= 1'b0;
        end
    end

    // holding register; emptied on disable
    always_ff @(posedge mclk) begin
        if (rst || !tx_run) begin
            hold      <= '0;
            hold_full <= 1'b0;
        end else if (wr_ok) begin
            hold      <= word_in;
            hold_full <= 1'b1;
        end else if (load_now) begin
            hold_full <= 1'b0;
        end
    end

    // empty flag: low from accepted write until shifter takes it
    always_ff @(posedge mclk) begin
        if (rst || !tx_run) begin
            tx_empty_flag <= 1'b1;
        end else if (wr_ok) begin
            tx_empty_flag <= 1'b0;
        end else if (load_now) begin
            tx_empty_flag <= 1'b1;
        end
    end

    // frame engine; abort on enable loss
    always_ff @(posedge mclk) begin
        if (rst || !tx_run) begin
            state        <= UFT_IDLE;
            tx_shift_reg <= '0;
            bit_cnt      <= '0;
            stop_cnt     <= 1'b0;
            par_acc      <= 1'b0;
            tx_out       <= 1'b1;
        end else if (tick) begin
            unique case (state)
                UFT_IDLE: begin
                    tx_out <= 1'b1;
                    if (hold_full) begin
                        tx_shift_reg <= hold;
                        state        <= UFT_START;
                    end
                end
                UFT_START: begin
                    tx_out  <= 1'b0;
                    bit_cnt <= '0;
                    par_acc <= cfg_par_odd;
                    state   <= UFT_DATA;
                end
                UFT_DATA: begin
                    // parity fills last slot of the word
                    if (cfg_par_en && (bit_cnt == word_bits - 4'h1)) begin
                        tx_out <= par_acc;
                    end else begin
                        tx_out  <= tx_shift_reg[0];
                        par_acc <= par_acc ^ tx_shift_reg[0];
                    end
                    tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                    if (bit_cnt == word_bits - 4'h1) begin
                        stop_cnt <= cfg_two_stop;
                        state    <= UFT_STOP;
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                UFT_STOP: begin
                    tx_out <= 1'b1;
                    if (stop_cnt) begin
                        stop_cnt <= 1'b0;
                    end else begin
                        state <= UFT_IDLE;
                    end
                end
            endcase
        end
    end

    // idle flag: set at frame end, cleared by the same sequence
    always_ff @(posedge mclk) begin
        if (rst || !tx_run) begin
            tx_idle_flag <= 1'b1;
        end else if (tick && state == UFT_STOP && !stop_cnt) begin
            tx_idle_flag <= 1'b1;
        end else if (wr_ok) begin
            tx_idle_flag <= 1'b0;
        end
    end

    // pin ownership registered so outputs come from flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_oe_n <= 1'b1;
            rx_take <= 1'b0;
        end else begin
            tx_oe_n <= !tx_run;
            rx_take <= port_on && rx_enable;
        end
    end

    // shared request; set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            shared_irq_flag <= 1'b0;
        end else if (tx_empty_irq_en && tx_empty_flag) begin
            shared_irq_flag <= 1'b1;
        end else if (shared_irq_clr) begin
            shared_irq_flag <= 1'b0;
        end
    end

    property p_write_ignored;
        @(posedge mclk) disable iff (rst)
        (data_write && !tx_empty_flag) |=> $stable(hold);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write accepted while empty flag low");

    property p_idle_high;
        @(posedge mclk) disable iff (rst)
        (state == UFT_IDLE && tx_run) |=> tx_out;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("idle line not high");

    property p_disable_flags;
        @(posedge mclk) disable iff (rst)
        !port_global_enable |=> (!tx_enable && !rx_enable && tx_empty_flag
                                 && tx_idle_flag && rx_idle_flag);
    endproperty
    a_disable_flags: assert property (p_disable_flags)
        else $error("disable did not reset flags");

    property p_abort;
        @(posedge mclk) disable iff (rst)
        !tx_run |=> (state == UFT_IDLE && !hold_full);
    endproperty
    a_abort: assert property (p_abort)
        else $error("transmitter not reset on disable");

    property p_pin_release;
        @(posedge mclk) disable iff (rst)
        !port_on |=> tx_oe_n;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("pin still driven");

    sequence s_start_bit;
        tick && state == UFT_START;
    endsequence
    property p_start_low;
        @(posedge mclk) disable iff (rst)
        s_start_bit |=> (!tx_out || !tx_run);
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not low");

    property p_clear_needs_arm;
        @(posedge mclk) disable iff (rst)
        ($fell(tx_empty_flag)) |-> $past(armed);
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm)
        else $error("empty flag cleared without status access");

    property p_irq;
        @(posedge mclk) disable iff (rst)
        (tx_empty_irq_en && tx_empty_flag) |=> shared_irq_flag;
    endproperty
    a_irq: assert property (p_irq)
        else $error("shared flag not raised");

    property p_load_sets_empty;
        @(posedge mclk) disable iff (rst)
        (load_now && tx_run && !wr_ok) |=> tx_empty_flag;
    endproperty
    a_load_sets_empty: assert property (p_load_sets_empty)
        else $error("empty flag not set on load");
endmodule : uft_transmitter
`default_nettype wire

/* uft_rx_model.sv */
// far-end receiver model: samples the tx line at mid-bit
`timescale 1ns/10ps
`default_nettype none
module uft_rx_model (
    input  wire logic        mclk,
    input  wire logic        line,
    input  wire logic [9:0]  bit_cyc,
    input  wire logic [3:0]  nbits,
    output logic      [15:0] bits,
    output logic      [7:0]  frames
);
    int i;
    initial begin
        bits = 16'h0000;
        frames = 8'h00;
        forever begin
            @(negedge line);
            repeat (bit_cyc / 2) @(posedge mclk);
            if (line === 1'b0) begin
                bits = 16'h0000;
                // stop bits are kept so their level can be compared too
                for (i = 0; i < nbits; i++) begin
                    repeat (bit_cyc) @(posedge mclk);
                    bits[i] = line;
                end
                frames = frames + 8'h01;
            end
        end
    end
endmodule : uft_rx_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the serial frame transmitter
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic       nine, pen, odd, two, hs;
        logic [7:0] dv, d;
        logic       b8;
    } uft_case_t;
    logic        mclk, rst, md, ge, tes, tec, res, rec, brs, w9, pto, pen;
    logic        tsc, b8, hs, ien, sa, dw, iclr;
    logic [7:0]  dv, din, frames, f0;
    logic [9:0]  bc;
    logic [3:0]  nb;
    logic [15:0] bits;
    logic        tx_out, tx_oe_n, rx_take, tx_enable, rx_enable;
    logic        break_request, tx_empty_flag, tx_idle_flag, rx_idle_flag;
    logic        rx_available_flag, shared_irq_flag;
    logic        cfg_nine, cfg_par_en, cfg_par_odd, cfg_two_stop;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          k;
    uft_case_t   c;
    uft_case_t   tbl [6] = '{'{0, 0, 0, 0, 1, 8'h00, 8'hA5, 0},
        '{1, 0, 0, 0, 1, 8'h00, 8'h3C, 1}, '{0, 1, 0, 0, 1, 8'h00, 8'h07, 0},
        '{0, 1, 1, 1, 1, 8'h00, 8'h07, 0}, '{1, 1, 1, 0, 0, 8'h01, 8'h81, 0},
        '{1, 1, 0, 1, 1, 8'h02, 8'hFF, 1}};
    // released pin is pulled up, so the far end sees a high line
    wire        tx_line = (tx_oe_n === 1'b0) ? tx_out : 1'b1;
    wire [3:0]  cfg = {cfg_nine, cfg_par_en, cfg_par_odd, cfg_two_stop};
    wire [10:0] st = {tx_out, tx_oe_n, rx_take, tx_enable, rx_enable,
        break_request, tx_empty_flag, tx_idle_flag, rx_idle_flag,
        rx_available_flag, shared_irq_flag};

    uft_transmitter i_dut (.mclk, .rst, .serial_mode_select(md),
        .port_global_enable(ge), .tx_enable_set(tes), .tx_enable_clr(tec),
        .rx_enable_set(res), .rx_enable_clr(rec), .break_request_set(brs),
        .word_len_nine(w9), .parity_type_sel(pto), .parity_enable(pen),
        .stop_count_sel(tsc), .tx_bit_eight(b8), .baud_high_speed(hs),
        .baud_divisor(dv), .tx_empty_irq_en(ien), .status_access(sa),
        .data_write(dw), .data_in(din), .shared_irq_clr(iclr), .tx_out,
        .tx_oe_n, .rx_take, .tx_enable, .rx_enable, .break_request,
        .tx_empty_flag, .tx_idle_flag, .rx_idle_flag, .rx_available_flag,
        .shared_irq_flag, .cfg_nine, .cfg_par_en, .cfg_par_odd,
        .cfg_two_stop);
    uft_rx_model i_far (.mclk, .line(tx_line), .bit_cyc(bc), .nbits(nb),
        .bits, .frames);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR t=%0t timeout", $time);
            finish_test();
        end
    end

    task automatic ck_st(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t flags %h exp %h", $time, got, exp);
        end
    endtask : ck_st

    task automatic ck_fr(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t frame %h exp %h", $time, got, exp);
        end
    endtask : ck_fr

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    // status access first: a bare write is refused by the device
    task automatic send(input logic [7:0] d, input logic b);
        @(posedge mclk);
        sa <= 1'b1;
        @(posedge mclk);
        sa <= 1'b0;
        dw <= 1'b1;
        din <= d;
        b8 <= b;
        @(posedge mclk);
        dw <= 1'b0;
    endtask : send

    task automatic wait_fr(input logic [7:0] f);
        int n;
        n = 0;
        while (frames === f && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        ck_fr(16'(frames !== f), 16'h0001);
    endtask : wait_fr

    function automatic logic [15:0] expf(input uft_case_t e);
        logic [15:0] f;
        int          w;
        w = e.nine ? 9 : 8;
        f = {7'h7f, e.nine ? e.b8 : 1'b1, e.d};
        if (e.pen) f[w-1] = e.odd ^ (^(f & ((16'h0001 << (w - 1)) - 1)));
        return f & ((16'h0001 << (w + 1 + e.two)) - 16'h0001);
    endfunction : expf

    initial begin
        {md, ge, tes, tec, res, rec, brs, w9, pto, pen, tsc, b8, hs, ien,
            sa, dw, iclr, dv, din} = '0;
        rst = 1'b1;
        bc = 10'h010;
        nb = 4'h9;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        ck_st(st, 11'h61C);
        ck_st(11'(cfg), 11'h000);
        @(posedge mclk);
        {md, ge, tes, res, hs} <= 5'h1F;
        @(posedge mclk);
        {tes, res} <= 2'h0;
        cyc(2);
        ck_st(st, 11'h5DC);
        @(posedge mclk);
        dw <= 1'b1;
        din <= 8'h55;
        @(posedge mclk);
        dw <= 1'b0;
        cyc(2);
        ck_st(st, 11'h5DC);
        for (k = 0; k < 6; k++) begin
            c = tbl[k];
            @(posedge mclk);
            {w9, pen, pto, tsc, hs, dv} <= {c.nine, c.pen, c.odd, c.two,
                c.hs, c.dv};
            bc <= 10'((c.hs ? 16 : 64) * (c.dv + 1));
            nb <= 4'(c.nine ? 10 : 9) + 4'(c.two);
            cyc(2);
            ck_st(11'(cfg), 11'({c.nine, c.pen, c.odd, c.two}));
            f0 = frames;
            send(c.d, c.b8);
            #1 ck_st(11'({tx_empty_flag, tx_idle_flag}), 11'h000);
            cyc(int'(bc) + 3);
            ck_st(11'({tx_empty_flag, tx_idle_flag}), 11'h002);
            wait_fr(f0);
            ck_fr(bits, expf(c));
            cyc(int'(bc));
            ck_st(st, 11'h5DC);
        end
        @(posedge mclk);
        {w9, pen, pto, tsc, hs, dv} <= 13'h0100;
        bc <= 10'h010;
        nb <= 4'h9;
        cyc(2);
        f0 = frames;
        send(8'h5A, 1'b0);
        cyc(20);
        send(8'hC3, 1'b0);
        #1 ck_st(11'(tx_empty_flag), 11'h000);
        send(8'h00, 1'b0);
        wait_fr(f0);
        ck_fr(bits, 16'h015A);
        wait_fr(f0 + 8'h01);
        ck_fr(bits, 16'h01C3);
        cyc(400);
        ck_fr(16'(frames - f0), 16'h0002);
        @(posedge mclk);
        ien <= 1'b1;
        cyc(2);
        ck_st(11'(shared_irq_flag), 11'h001);
        @(posedge mclk);
        iclr <= 1'b1;
        ien <= 1'b0;
        @(posedge mclk);
        iclr <= 1'b0;
        cyc(3);
        ck_st(11'(shared_irq_flag), 11'h000);
        // abort by transmit enable drop in mid-frame
        send(8'h00, 1'b0);
        cyc(60);
        tec <= 1'b1;
        @(posedge mclk);
        tec <= 1'b0;
        cyc(2);
        ck_st(st, 11'h75C);
        @(posedge mclk);
        {tes, brs, tsc} <= 3'h7;
        @(posedge mclk);
        {tes, brs} <= 2'h0;
        cyc(300);
        ck_st(11'(break_request), 11'h001);
        send(8'h00, 1'b0);
        cyc(60);
        ge <= 1'b0;
        cyc(2);
        ck_st(st, 11'h61C);
        ck_st(11'(cfg), 11'h001);
        @(posedge mclk);
        {ge, tes} <= 2'h3;
        nb <= 4'hA;
        @(posedge mclk);
        tes <= 1'b0;
        cyc(300);
        f0 = frames;
        send(8'h3C, 1'b0);
        wait_fr(f0);
        ck_fr(bits, 16'h033C);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
